// *** verilog/lrp_defs.svh ***
// Contract
// [RULE1] Startup step time code bits 2:0
// [RULE2] Shutdown step time code bits 5:3
// [RULE3] Startup rate until target reached
// [RULE4] Shutdown rate until current reaches zero
// [RULE5] One shared setting for all sinks
// [RULE6] Run-time up bits 2:0, down 5:3
// [RULE7] Run-time rates only after initial target
// [RULE8] Bank bit 0 selects PWM input
// [RULE9] Bank bit 1 sets PWM polarity
// [RULE10] Bits 6:2 enable PWM per zone
// [RULE11] Three bank registers at 0x13-0x15
// [RULE12] Two-bit code routes bank to sink
// [RULE13] Each step moves one of 256 levels
// [RULE14] Zone disabled means no PWM modulation
`ifndef LRP_DEFS_SVH
`define LRP_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LRP_ADDR_STATUS     8'h0F
`define LRP_ADDR_ROUTING    8'h10
`define LRP_ADDR_POWER_RAMP 8'h11
`define LRP_ADDR_RUN_RAMP   8'h12
`define LRP_ADDR_BANK_A     8'h13
`define LRP_ADDR_BANK_B     8'h14
`define LRP_ADDR_BANK_C     8'h15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LRP_RST_ROUTING     8'h24
`define LRP_RST_POWER_RAMP  8'h00
`define LRP_RST_RUN_RAMP    8'h00
`define LRP_RST_BANK_PWM    8'h02

// ----------------------------------------
// Field widths and limits
// ----------------------------------------
`define LRP_ROUTE_BITS      2
`define LRP_ZONE_COUNT      5
`define LRP_LEVEL_MAX       8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define LRP_CLK_PERIOD_NS   8
`define LRP_STEP_FAST_NS    8000
`define LRP_STEP_SLOW_NS    1024000
`define LRP_STEP_FAST_CYC   (`LRP_STEP_FAST_NS / `LRP_CLK_PERIOD_NS)
`define LRP_STEP_SLOW_CYC   (`LRP_STEP_SLOW_NS / `LRP_CLK_PERIOD_NS)

`endif

// *** verilog/lrp_pkg.sv ***
package lrp_pkg;

   typedef enum logic [3:0] {
      LRP_OFF      = 4'h1,
      LRP_STARTUP  = 4'h2,
      LRP_RUN      = 4'h4,
      LRP_SHUTDOWN = 4'h8
   } lrp_phase_e;

   typedef struct packed {
      logic [1:0] unused;
      logic [2:0] down;
      logic [2:0] up;
   } lrp_ramp_cfg_s;

   typedef struct packed {
      logic       unused;
      logic [4:0] zone_en;
      logic       active_high;
      logic       use_second;
   } lrp_pwm_cfg_s;

   typedef struct packed {
      logic [7:0] level;
      logic       drive;
   } lrp_sink_s;

   typedef logic [22:0] lrp_cnt_t;

endpackage

// *** verilog/lrp_pwm_gate.sv ***
`include "lrp_defs.svh"

module lrp_pwm_gate
   import lrp_pkg::*;
(
   input  wire lrp_pwm_cfg_s cfg_i,
   input  wire logic [2:0]   zone_i,
   input  wire logic         pwm_first_i,
   input  wire logic         pwm_second_i,
   output logic              drive_o
);

   logic raw;
   logic zone_on;

   always_comb
   begin
      raw     = cfg_i.use_second ? pwm_second_i : pwm_first_i;       // RULE8
      zone_on = (zone_i < 3'(`LRP_ZONE_COUNT)) && cfg_i.zone_en[zone_i]; // RULE10
      if (zone_on)
      begin
         drive_o = cfg_i.active_high ? raw : ~raw;                  // RULE9
      end
      else
      begin
         drive_o = 1'b1;                                             // RULE14
      end
   end

endmodule // lrp_pwm_gate

// *** verilog/lrp_ramp_unit.sv ***
`include "lrp_defs.svh"

module lrp_ramp_unit
   import lrp_pkg::*;
#(
   parameter lrp_cnt_t STEP_FAST = 23'(`LRP_STEP_FAST_CYC),
   parameter lrp_cnt_t STEP_SLOW = 23'(`LRP_STEP_SLOW_CYC)
)
(
   input  wire logic          clk_sys_i,
   input  wire logic          nrst_i,
   input  wire logic          enable_i,
   input  wire logic [7:0]    target_i,
   input  wire lrp_ramp_cfg_s power_cfg_i,
   input  wire lrp_ramp_cfg_s run_cfg_i,
   output logic [7:0]         level_o,
   output logic               busy_o
);

   lrp_phase_e phase_ff;
   lrp_phase_e nxt_phase;
   logic [7:0] level_ff;
   logic [7:0] nxt_level;
   lrp_cnt_t   cnt_ff;
   lrp_cnt_t   nxt_cnt;
   logic [7:0] dest;
   logic [2:0] code;
   lrp_cnt_t   period;

   function automatic lrp_cnt_t step_cycles(input logic [2:0] c);
      if (c == 3'h0)
         step_cycles = STEP_FAST;
      else
         step_cycles = STEP_SLOW << (c - 3'h1);
   endfunction

   // ----------------------------------------
   // Phase, level and step timer
   // ----------------------------------------
   always_comb
   begin
      nxt_phase = phase_ff;
      dest      = target_i;
      code      = power_cfg_i.up;
      case (phase_ff)
         LRP_OFF:
         begin
            dest = 8'h00;
            if (enable_i)
               nxt_phase = LRP_STARTUP;
         end
         LRP_STARTUP:
         begin
            code = power_cfg_i.up;                                   // RULE1 RULE3
            if (!enable_i)
               nxt_phase = LRP_SHUTDOWN;
            else if (level_ff == target_i)
               nxt_phase = LRP_RUN;
         end
         LRP_RUN:
         begin
            code = (target_i > level_ff) ? run_cfg_i.up : run_cfg_i.down; // RULE6 RULE7
            if (!enable_i)
               nxt_phase = LRP_SHUTDOWN;
         end
         LRP_SHUTDOWN:
         begin
            dest = 8'h00;
            code = power_cfg_i.down;                                 // RULE2 RULE4
            if (enable_i)
               nxt_phase = LRP_STARTUP;
            else if (level_ff == 8'h00)
               nxt_phase = LRP_OFF;
         end
         default:
         begin
            dest      = 8'h00;
            nxt_phase = LRP_OFF;
         end
      endcase
      period    = step_cycles(code);
      nxt_level = level_ff;
      nxt_cnt   = '0;
      if (level_ff != dest)
      begin
         if (cnt_ff >= period - 23'h1)
         begin
            nxt_level = (dest > level_ff) ? level_ff + 8'h01 : level_ff - 8'h01; // RULE13
         end
         else
         begin
            nxt_cnt = cnt_ff + 23'h1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         phase_ff <= LRP_OFF;
         level_ff <= 8'h00;
         cnt_ff   <= '0;
      end
      else
      begin
         phase_ff <= nxt_phase;
         level_ff <= nxt_level;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign level_o = level_ff;
   assign busy_o  = (phase_ff == LRP_STARTUP) || (phase_ff == LRP_SHUTDOWN);

endmodule // lrp_ramp_unit

// *** verilog/lrp_top.sv ***
`include "lrp_defs.svh"

module lrp_top
   import lrp_pkg::*;
#(
   parameter lrp_cnt_t STEP_FAST = 23'(`LRP_STEP_FAST_CYC),
   parameter lrp_cnt_t STEP_SLOW = 23'(`LRP_STEP_SLOW_CYC)
)
(
   input  wire logic        clk_sys_i,
   input  wire logic        nrst_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic [7:0]       reg_rdata_o,
   input  wire logic [2:0]  bank_enable_i,
   input  wire logic [7:0]  bank_a_target_i,
   input  wire logic [7:0]  bank_b_target_i,
   input  wire logic [7:0]  bank_c_target_i,
   input  wire logic [2:0]  bank_a_zone_i,
   input  wire logic [2:0]  bank_b_zone_i,
   input  wire logic [2:0]  bank_c_zone_i,
   input  wire logic        pwm_input_first_i,
   input  wire logic        pwm_input_second_i,
   output lrp_sink_s        current_sink_one_o,
   output lrp_sink_s        current_sink_two_o,
   output lrp_sink_s        current_sink_three_o
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0]    routing_ff;
   logic [7:0]    nxt_routing;
   lrp_ramp_cfg_s power_ramp_rate_ff;
   lrp_ramp_cfg_s nxt_power_ramp_rate;
   lrp_ramp_cfg_s runtime_ramp_rate_ff;
   lrp_ramp_cfg_s nxt_runtime_ramp_rate;
   lrp_pwm_cfg_s  bank_pwm_config_ff [3];
   lrp_pwm_cfg_s  nxt_bank_pwm_config [3];
   logic [7:0]    rdata_ff;
   logic [7:0]    nxt_rdata;
   logic [2:0]    busy;

   always_comb
   begin
      nxt_routing           = routing_ff;
      nxt_power_ramp_rate   = power_ramp_rate_ff;
      nxt_runtime_ramp_rate = runtime_ramp_rate_ff;
      nxt_bank_pwm_config   = bank_pwm_config_ff;
      nxt_rdata             = rdata_ff;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            `LRP_ADDR_ROUTING:    nxt_routing = {2'b00, reg_wdata_i[5:0]};
            `LRP_ADDR_POWER_RAMP: nxt_power_ramp_rate = {2'b00, reg_wdata_i[5:0]}; // RULE5
            `LRP_ADDR_RUN_RAMP:   nxt_runtime_ramp_rate = {2'b00, reg_wdata_i[5:0]};
            `LRP_ADDR_BANK_A:     nxt_bank_pwm_config[0] = {1'b0, reg_wdata_i[6:0]}; // RULE11
            `LRP_ADDR_BANK_B:     nxt_bank_pwm_config[1] = {1'b0, reg_wdata_i[6:0]}; // RULE11
            `LRP_ADDR_BANK_C:     nxt_bank_pwm_config[2] = {1'b0, reg_wdata_i[6:0]}; // RULE11
            default:              nxt_routing = routing_ff;
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            `LRP_ADDR_STATUS:     nxt_rdata = {5'h00, busy};
            `LRP_ADDR_ROUTING:    nxt_rdata = routing_ff;
            `LRP_ADDR_POWER_RAMP: nxt_rdata = power_ramp_rate_ff;
            `LRP_ADDR_RUN_RAMP:   nxt_rdata = runtime_ramp_rate_ff;
            `LRP_ADDR_BANK_A:     nxt_rdata = bank_pwm_config_ff[0];
            `LRP_ADDR_BANK_B:     nxt_rdata = bank_pwm_config_ff[1];
            `LRP_ADDR_BANK_C:     nxt_rdata = bank_pwm_config_ff[2];
            default:              nxt_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         routing_ff             <= `LRP_RST_ROUTING;
         power_ramp_rate_ff     <= `LRP_RST_POWER_RAMP;
         runtime_ramp_rate_ff   <= `LRP_RST_RUN_RAMP;
         bank_pwm_config_ff[0]  <= `LRP_RST_BANK_PWM;
         bank_pwm_config_ff[1]  <= `LRP_RST_BANK_PWM;
         bank_pwm_config_ff[2]  <= `LRP_RST_BANK_PWM;
         rdata_ff               <= 8'h00;
      end
      else
      begin
         routing_ff             <= nxt_routing;
         power_ramp_rate_ff     <= nxt_power_ramp_rate;
         runtime_ramp_rate_ff   <= nxt_runtime_ramp_rate;
         bank_pwm_config_ff     <= nxt_bank_pwm_config;
         rdata_ff               <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // ----------------------------------------
   // PWM pin synchroniser
   // ----------------------------------------
   logic [1:0] pwm_meta_ff;
   logic [1:0] pwm_sync_ff;

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pwm_meta_ff <= 2'b00;
         pwm_sync_ff <= 2'b00;
      end
      else
      begin
         pwm_meta_ff <= {pwm_input_second_i, pwm_input_first_i};
         pwm_sync_ff <= pwm_meta_ff;
      end
   end

   // ----------------------------------------
   // Per-bank ramp and PWM gating
   // ----------------------------------------
   logic [7:0] bank_target [3];
   logic [2:0] bank_zone   [3];
   logic [7:0] bank_level  [3];
   logic [2:0] bank_drive;

   assign bank_target[0] = bank_a_target_i;
   assign bank_target[1] = bank_b_target_i;
   assign bank_target[2] = bank_c_target_i;
   assign bank_zone[0]   = bank_a_zone_i;
   assign bank_zone[1]   = bank_b_zone_i;
   assign bank_zone[2]   = bank_c_zone_i;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_bank
         lrp_ramp_unit #(
            .STEP_FAST (STEP_FAST),
            .STEP_SLOW (STEP_SLOW)
         ) u_ramp (
            .clk_sys_i   (clk_sys_i),
            .nrst_i      (nrst_i),
            .enable_i    (bank_enable_i[g]),
            .target_i    (bank_target[g]),
            .power_cfg_i (power_ramp_rate_ff),
            .run_cfg_i   (runtime_ramp_rate_ff),
            .level_o     (bank_level[g]),
            .busy_o      (busy[g])
         );

         lrp_pwm_gate u_gate (
            .cfg_i        (bank_pwm_config_ff[g]),
            .zone_i       (bank_zone[g]),
            .pwm_first_i  (pwm_sync_ff[0]),
            .pwm_second_i (pwm_sync_ff[1]),
            .drive_o      (bank_drive[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Sink routing
   // ----------------------------------------
   function automatic logic [1:0] bank_of(input logic [1:0] c);
      if (c[1])
         bank_of = 2'd2;
      else
         bank_of = {1'b0, c[0]};
   endfunction

   lrp_sink_s sink_ff     [3];
   lrp_sink_s nxt_sink    [3];
   logic [1:0] sel        [3];

   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         sel[i]            = bank_of(routing_ff[2*i +: 2]);            // RULE12
         nxt_sink[i].level = bank_level[sel[i]];
         nxt_sink[i].drive = bank_drive[sel[i]];
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sink_ff[0] <= '0;
         sink_ff[1] <= '0;
         sink_ff[2] <= '0;
      end
      else
      begin
         sink_ff <= nxt_sink;
      end
   end

   assign current_sink_one_o   = sink_ff[0];
   assign current_sink_two_o   = sink_ff[1];
   assign current_sink_three_o = sink_ff[2];

endmodule // lrp_top

// *** dv/lrp_pwm_src.sv ***
// ------
// PWM sources
// ------
module lrp_pwm_src
(
   input  wire logic       free_i,
   input  wire logic [1:0] hold_i,
   output logic            pwm_first_o,
   output logic            pwm_second_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wave = 2'h0;
   // Unrelated rates, toggles land on clock edges
   always #52 wave[0] = ~wave[0];
   always #84 wave[1] = ~wave[1];
   assign pwm_first_o  = free_i ? wave[0] : hold_i[0];
   assign pwm_second_o = free_i ? wave[1] : hold_i[1];
endmodule // lrp_pwm_src

// *** dv/lrp_top_sva.sv ***
module lrp_top_sva
   import lrp_pkg::*;
#(
   parameter lrp_cnt_t STEP_FAST = 23'h3E8
)
(
   input wire logic       clk_sys_i,
   input wire logic       nrst_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [2:0] bank_enable_i,
   input wire logic [2:0] bank_a_zone_i,
   input wire logic [2:0] bank_b_zone_i,
   input wire logic [2:0] bank_c_zone_i,
   input wire lrp_sink_s  current_sink_one_o,
   input wire lrp_sink_s  current_sink_two_o,
   input wire lrp_sink_s  current_sink_three_o
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [7:0] lvl = current_sink_one_o.level;
   wire logic drv_all = current_sink_one_o.drive & current_sink_two_o.drive
                        & current_sink_three_o.drive;
   wire logic zoff = (bank_a_zone_i > 3'h4) & (bank_b_zone_i > 3'h4) & (bank_c_zone_i > 3'h4);
   lrp_cnt_t since_ff;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // Cycles since last level step
   always_ff @(posedge clk_sys_i or negedge nrst_i)
      if (!nrst_i)
         since_ff <= '0;
      else if ($changed(lvl))
         since_ff <= '0;
      else
         since_ff <= since_ff + 23'h1;
   // ------
   // Checks
   // ------
   a_rdata_hold:
      assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
   a_ramp_readback:
      assert property (reg_wr_i && reg_addr_i inside {8'h11, 8'h12} ##1 reg_rd_i && !reg_wr_i
         && $stable(reg_addr_i) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F))
      else $error("ramp register readback wrong");
   a_bank_readback:
      assert property (reg_wr_i && reg_addr_i inside {[8'h13:8'h15]} ##1 reg_rd_i && !reg_wr_i
         && $stable(reg_addr_i) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h7F))
      else $error("bank register readback wrong");
   a_unmapped_zero:
      assert property (reg_rd_i && reg_addr_i > 8'h15 |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   a_step_single:
      assert property ($changed(lvl) |-> (lvl - $past(lvl) == 8'h01)
         || ($past(lvl) - lvl == 8'h01)) else $error("level step not one");
   a_step_spacing:
      assert property ($changed(lvl) |-> since_ff >= STEP_FAST - 23'h1)
      else $error("level steps too close");
   a_nomod_drive:
      assert property (zoff[*3] |-> drv_all) else $error("sink modulated in disabled zone");
   a_off_no_rise:
      assert property ((bank_enable_i == 3'h0 && !reg_wr_i)[*3] |=> lvl <= $past(lvl))
      else $error("level rose while disabled");
   c_readback: cover property (reg_wr_i ##1 reg_rd_i);
   c_top_step: cover property ($changed(lvl) && lvl == 8'h04);
   c_pwm_low: cover property ($fell(current_sink_one_o.drive));
endmodule // lrp_top_sva

bind lrp_top lrp_top_sva #(.STEP_FAST(STEP_FAST)) lrp_top_sva_inst (.*);

// *** dv/led_ramp_and_pwm_routing_test.sv ***
`define CHK(a, e) \
   begin \
      checks++; \
      if ((a) !== (e)) \
      begin \
         failures++; \
         $display("wrong value at %0t got %h expected %h", $time, a, e); \
      end \
   end

module led_ramp_and_pwm_routing_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lrp_pkg::*;
   localparam int LIMIT = 30000;
   logic        clk_sys_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [7:0]  reg_rdata_o;
   logic [2:0]  bank_enable_i = 3'h0;
   logic [7:0]  tgt = 8'h00;
   logic [2:0]  z [3] = '{3'h7, 3'h7, 3'h7};
   logic        free = 1'b1;
   logic [1:0]  hold = 2'h0;
   logic        look = 1'b0;
   logic        ramp_on = 1'b0;
   wire logic   pwm_input_first_i;
   wire logic   pwm_input_second_i;
   lrp_sink_s   current_sink_one_o;
   lrp_sink_s   current_sink_two_o;
   lrp_sink_s   current_sink_three_o;
   wire logic [2:0] drives = {current_sink_three_o.drive, current_sink_two_o.drive,
                              current_sink_one_o.drive};
   logic [31:0] lq [$];
   logic [7:0]  rq [$];
   logic [2:0]  dq [$];
   logic [23:0] gap = 24'h0;
   logic [31:0] e;
   logic [7:0]  cf [3];
   logic [7:0]  rt;
   logic [7:0]  ua;
   logic [2:0]  ex;
   logic [2:0]  c;
   int          failures = 0;
   int          checks = 0;

   lrp_top #(.STEP_FAST(23'h4), .STEP_SLOW(23'h8)) lrp_top_inst (.*,
      .bank_a_target_i(tgt), .bank_b_target_i(tgt), .bank_c_target_i(tgt),
      .bank_a_zone_i(z[0]), .bank_b_zone_i(z[1]), .bank_c_zone_i(z[2]));
   lrp_pwm_src lrp_pwm_src_inst (.free_i(free), .hold_i(hold),
      .pwm_first_o(pwm_input_first_i), .pwm_second_o(pwm_input_second_i));

   always #4 clk_sys_i = ~clk_sys_i;

   // ------
   // Helpers
   // ------
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask

   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      tick();
      reg_wr_i = w;
      reg_rd_i = r;
      reg_addr_i = a;
      reg_wdata_i = d;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      rq.push_back(x);
      acc(1'b0, 1'b1, a, 8'h00);
      acc(1'b0, 1'b0, a, 8'h00);
   endtask

   task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] x);
      acc(1'b1, 1'b0, a, d);
      rd(a, x);
   endtask

   task automatic go(input logic [2:0] en, input logic [7:0] t, input logic [2:0] st);
      tick();
      bank_enable_i = en;
      tgt = t;
      rd(8'h0F, {5'h00, st});
      for (int n = 0; n < 3000 && current_sink_one_o.level !== t; n++)
         tick();
      tick();
   endtask

   function automatic logic [23:0] per(input logic [2:0] k);
      return (k == 3'h0) ? 24'h4 : (24'h8 << (k - 3'h1));
   endfunction

   function automatic logic drv(input logic [1:0] sel, input logic [1:0] p);
      int b;
      b = sel[1] ? 2 : int'(sel[0]);
      if (z[b] > 3'h4 || !cf[b][z[b] + 3'h2])
         return 1'b1;
      return p[cf[b][0]] ~^ cf[b][1];
   endfunction

   task automatic results();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------
   // Monitors
   // ------
   always @(posedge clk_sys_i)
      gap++;

   always @(current_sink_one_o.level)
      if (ramp_on)
      begin
         #1;
         e = lq.pop_front();
         `CHK(current_sink_one_o.level, e[7:0])
         `CHK(current_sink_two_o.level, e[7:0])
         `CHK(current_sink_three_o.level, e[7:0])
         if (e[31:8] != 24'h0)
            `CHK(gap, e[31:8])
         gap = 24'h0;
      end

   always @(posedge clk_sys_i)
      if (reg_rd_i === 1'b1)
      begin
         #2;
         `CHK(reg_rdata_o, rq.pop_front())
      end

   always @(posedge clk_sys_i)
      if (look === 1'b1)
      begin
         #2;
         `CHK(drives, dq.pop_front())
      end

   // ------
   // Tests
   // ------
   initial
   begin
      void'($urandom(32'h36A6));
      repeat (8) @(posedge clk_sys_i);
      #1 nrst_i = 1'b1;
      rd(8'h10, 8'h24);
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      for (int b = 0; b < 3; b++)
         rd(8'h13 + 8'(b), 8'h02);
      ua = 8'($urandom_range(8'hFF, 8'h16));
      acc(1'b1, 1'b0, ua, 8'hFF);
      acc(1'b1, 1'b0, 8'h0F, 8'hFF);
      rd(ua, 8'h00);
      rd(8'h0F, 8'h00);
      $display("register test done");
      ramp_on = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         c = 3'(k);
         wrd(8'h11, {2'($urandom), ~c, c}, {2'h0, ~c, c});
         wrd(8'h12, {2'($urandom), c, ~c}, {2'h0, c, ~c});
         lq = '{{24'h0, 8'h01}, {per(c), 8'h02}, {24'h0, 8'h03}, {per(~c), 8'h04},
                {24'h0, 8'h03}, {per(c), 8'h02}, {24'h0, 8'h01}, {per(~c), 8'h00}};
         go(3'h7, 8'h02, 3'h7);
         go(3'h7, 8'h04, 3'h0);
         go(3'h7, 8'h02, 3'h0);
         go(3'h0, 8'h00, 3'h7);
         `CHK(lq.size(), 0)
      end
      ramp_on = 1'b0;
      $display("ramp test done");
      free = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         rt = 8'($urandom);
         hold = 2'($urandom);
         wrd(8'h10, rt, rt & 8'h3F);
         for (int b = 0; b < 3; b++)
         begin
            cf[b] = 8'($urandom);
            z[b] = 3'($urandom);
            wrd(8'h13 + 8'(b), cf[b], cf[b] & 8'h7F);
         end
         repeat (4) tick();
         for (int s = 0; s < 3; s++)
            ex[s] = drv(rt[2 * s +: 2], hold);
         dq.push_back(ex);
         look = 1'b1;
         tick();
         look = 1'b0;
      end
      $display("pwm test done");
      results();
   end

   initial
   begin
      repeat (LIMIT) @(posedge clk_sys_i);
      failures++;
      results();
   end
endmodule // led_ramp_and_pwm_routing_test
